// ===== cmtim_pkg.sv
package cmtim_pkg;
   // Register byte offsets on the APB side
   localparam logic [11:0] OFS_CTL0 = 12'h000;
   localparam logic [11:0] OFS_CTL1 = 12'h004;
   localparam logic [11:0] OFS_CNT_LO = 12'h008;
   localparam logic [11:0] OFS_CNT_HI = 12'h00c;
   localparam logic [11:0] OFS_CMPA_LO = 12'h010;
   localparam logic [11:0] OFS_CMPA_HI = 12'h014;
   // Reset values
   localparam logic [7:0] CTL0_RST = 8'h00;
   localparam logic [7:0] CTL1_RST = 8'h00;
   localparam logic [9:0] CMPA_RST = 10'h000;
   // Control zero field positions
   localparam int C0_PAUSE = 7;
   localparam int C0_CKSEL_HI = 6;
   localparam int C0_CKSEL_LO = 4;
   localparam int C0_ON = 3;
   localparam int C0_PER_HI = 2;
   // Control one field positions
   localparam int C1_MODE_HI = 7;
   localparam int C1_MODE_LO = 6;
   localparam int C1_IOF_HI = 5;
   localparam int C1_IOF_LO = 4;
   localparam int C1_INIT = 3;
   localparam int C1_POL = 2;
   localparam int C1_SWAP = 1;
   localparam int C1_CLRSEL = 0;
   // Counter geometry and prescaler counts
   localparam int CNT_W = 10;
   localparam int PER_SHIFT = 7;
   localparam logic [1:0] SYS_DIV_LAST = 2'h3;
   localparam logic [5:0] HI16_MASK = 6'h0f;
   localparam logic [5:0] HI64_MASK = 6'h3f;
   // Clock select codes
   localparam logic [2:0] CK_SYS4 = 3'h0;
   localparam logic [2:0] CK_SYS = 3'h1;
   localparam logic [2:0] CK_HI16 = 3'h2;
   localparam logic [2:0] CK_HI64 = 3'h3;
   localparam logic [2:0] CK_SUB_A = 3'h4;
   localparam logic [2:0] CK_SUB_B = 3'h5;
   localparam logic [2:0] CK_EXT_RISE = 3'h6;
   localparam logic [2:0] CK_EXT_FALL = 3'h7;
   // Output function codes
   localparam logic [1:0] IOF_00 = 2'h0;
   localparam logic [1:0] IOF_01 = 2'h1;
   localparam logic [1:0] IOF_10 = 2'h2;
   localparam logic [1:0] IOF_11 = 2'h3;
   // Operating modes, in field order
   typedef enum {MODE_CMP, MODE_UNDEF, MODE_PWM, MODE_TMR} cmtim_mode_e;
endpackage

// ===== cmtim_tick_if.sv
`timescale 1ns/10ps
interface cmtim_tick_if;
   logic [2:0] clock_select;
   logic tick;
   modport gen (input clock_select, output tick);
   modport use_tick (output clock_select, input tick);
endinterface

// ===== cmtim_tick_gen.sv
`timescale 1ns/10ps
module cmtim_tick_gen (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Asynchronous clock sources
   input wire logic high_clk,
   input wire logic sub_clk,
   input wire logic external_count_input,
   // Tick selection
   cmtim_tick_if.gen tk
);
   logic [2:0] sync1;
   logic [2:0] sync2;
   logic [2:0] sync3;
   logic [2:0] rise;
   logic [1:0] sys_div;
   logic [5:0] hi_div;
   logic next_tick;

   // Two stages per source, third stage only for edge detection
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
         sync3 <= 3'h0;
      end else begin
         sync1 <= {external_count_input, sub_clk, high_clk};
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   assign rise = sync2 & ~sync3;

   // Prescaler for the system quarter rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_div <= 2'h0;
      end else begin
         sys_div <= sys_div + 2'h1;
      end
   end

   // Prescaler counting high clock edges; one counter serves both ratios
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_div <= 6'h00;
      end else if (rise[0]) begin
         hi_div <= hi_div + 6'h01;
      end
   end

   // Source selection
   always_comb begin
      case (tk.clock_select)
         cmtim_pkg::CK_SYS4: next_tick = sys_div == cmtim_pkg::SYS_DIV_LAST;
         cmtim_pkg::CK_SYS: next_tick = 1'b1;
         cmtim_pkg::CK_HI16: next_tick = rise[0] &&
            ((hi_div & cmtim_pkg::HI16_MASK) == cmtim_pkg::HI16_MASK);
         cmtim_pkg::CK_HI64: next_tick = rise[0] &&
            (hi_div == cmtim_pkg::HI64_MASK);
         cmtim_pkg::CK_SUB_A, cmtim_pkg::CK_SUB_B: next_tick = rise[1];
         cmtim_pkg::CK_EXT_RISE: next_tick = rise[2];
         cmtim_pkg::CK_EXT_FALL: next_tick = ~sync2[2] & sync3[2];
         default: next_tick = 1'b0;
      endcase
   end

   // Registered so the counter sees a clean one-cycle strobe
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tk.tick <= 1'b0;
      end else begin
         tk.tick <= next_tick;
      end
   end
endmodule // cmtim_tick_gen

// ===== cmtim_top.sv
`timescale 1ns/10ps
module cmtim_top #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Clock sources from outside
   input wire logic high_clk,
   input wire logic sub_clk,
   input wire logic external_count_input,
   // Timer outputs
   output logic timer_output_pin,
   output logic timer_output_en,
   output logic compare_a_flag,
   output logic compare_p_flag,
   output logic timer_event
);
   logic [7:0] ctl0;
   logic [7:0] ctl1;
   logic [9:0] count;
   logic [9:0] compare_a_value;
   logic [7:0] lo_buf;
   logic on_prev;
   logic on_rise;
   logic run;
   logic [10:0] nxt;
   logic a_hit;
   logic p_hit;
   logic ovf;
   logic period_by_a;
   logic clr_now;
   logic a_evt;
   logic p_evt;
   logic [10:0] duty;
   logic pwm_active;
   logic out_level;
   logic next_pin;
   logic next_en;
   logic access;
   logic done;
   logic [11:0] ofs;
   logic [31:0] next_rdata;
   logic next_err;
   logic [2:0] period_compare_value;
   logic [1:0] output_function_select;
   logic counter_on;
   logic counter_pause;
   logic output_initial_level;
   logic output_polarity;
   logic period_duty_swap;
   logic clear_condition_select;
   cmtim_pkg::cmtim_mode_e mode;
   cmtim_tick_if tk ();

   // Field views of the control registers
   assign counter_pause = ctl0[cmtim_pkg::C0_PAUSE];
   assign counter_on = ctl0[cmtim_pkg::C0_ON];
   assign period_compare_value = ctl0[cmtim_pkg::C0_PER_HI:0];
   assign tk.clock_select =
      ctl0[cmtim_pkg::C0_CKSEL_HI:cmtim_pkg::C0_CKSEL_LO];
   assign mode = cmtim_pkg::cmtim_mode_e'(
      ctl1[cmtim_pkg::C1_MODE_HI:cmtim_pkg::C1_MODE_LO]);
   assign output_function_select =
      ctl1[cmtim_pkg::C1_IOF_HI:cmtim_pkg::C1_IOF_LO];
   assign output_initial_level = ctl1[cmtim_pkg::C1_INIT];
   assign output_polarity = ctl1[cmtim_pkg::C1_POL];
   assign period_duty_swap = ctl1[cmtim_pkg::C1_SWAP];
   assign clear_condition_select = ctl1[cmtim_pkg::C1_CLRSEL];

   // Tick source: prescalers and synchronisers live here
   cmtim_tick_gen u_cmtim_tick_gen (
      .pclk(pclk),
      .presetn(presetn),
      .high_clk(high_clk),
      .sub_clk(sub_clk),
      .external_count_input(external_count_input),
      .tk(tk)
   );

   // Period bits as an eleven-bit clock count; zero gives the full range
   function automatic logic [10:0] period_count(input logic [2:0] p);
      if (p == 3'h0) begin
         period_count = 11'h400;
      end else begin
         period_count = {1'b0, p, 7'h00};
      end
   endfunction

   // APB decode
   assign access = psel & penable & ~pready;
   assign done = psel & penable & pready;
   assign ofs = 12'(paddr);

   // Edge of counter-on and the run gate
   assign on_rise = counter_on & ~on_prev;
   assign run = counter_on & ~counter_pause & ~on_rise;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         on_prev <= 1'b0;
      end else begin
         on_prev <= counter_on;
      end
   end

   // Comparators look at the value the counter is about to take
   assign nxt = {1'b0, count} + 11'h001;
   assign a_hit = (nxt[9:0] == compare_a_value) &&
      (compare_a_value != 10'h000);
   assign p_hit = (nxt[9:cmtim_pkg::PER_SHIFT] == period_compare_value) &&
      (nxt[cmtim_pkg::PER_SHIFT-1:0] == 7'h00) &&
      (period_compare_value != 3'h0);
   assign ovf = nxt[10];

   // PWM uses the swap bit; other modes the clear select
   assign period_by_a = (mode == cmtim_pkg::MODE_PWM) ?
      period_duty_swap : clear_condition_select;
   // Overflow only reaches here when the chosen comparator is zero
   assign clr_now = period_by_a ? (a_hit | ovf) : (p_hit | ovf);

   // P flag is suppressed when A owns the clear outside PWM
   assign a_evt = tk.tick & run & a_hit;
   assign p_evt = tk.tick & run & (p_hit |
      (ovf & (period_compare_value == 3'h0))) &
      ~((mode != cmtim_pkg::MODE_PWM) & clear_condition_select);

   // Main counter; software reaches it only through counter-on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= 10'h000;
      end else if (on_rise) begin
         count <= 10'h000;
      end else if (tk.tick & run) begin
         count <= clr_now ? 10'h000 : nxt[9:0];
      end
   end

   // Event pulses, one cycle each
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_a_flag <= 1'b0;
         compare_p_flag <= 1'b0;
         timer_event <= 1'b0;
      end else begin
         compare_a_flag <= a_evt;
         compare_p_flag <= p_evt;
         timer_event <= tk.tick & run & clr_now;
      end
   end

   // Compare-mode pin level; P matches never touch it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_level <= 1'b0;
      end else if (mode == cmtim_pkg::MODE_CMP) begin
         if (on_rise) begin
            out_level <= output_initial_level;
         end else if (a_evt) begin
            case (output_function_select)
               cmtim_pkg::IOF_01: out_level <= 1'b0;
               cmtim_pkg::IOF_10: out_level <= 1'b1;
               cmtim_pkg::IOF_11: out_level <= ~out_level;
               default: out_level <= out_level;
            endcase
         end
      end
   end

   // PWM duty from whichever comparator is not setting the period
   assign duty = period_duty_swap ? period_count(period_compare_value) :
      {1'b0, compare_a_value};
   // A duty at or past the period simply stays active all period
   assign pwm_active = {1'b0, count} < duty;

   // Pin value per mode; timer mode releases the pin
   always_comb begin
      next_pin = 1'b0;
      next_en = 1'b0;
      case (mode)
         cmtim_pkg::MODE_CMP: begin
            next_pin = out_level ^ output_polarity;
            next_en = 1'b1;
         end
         cmtim_pkg::MODE_PWM: begin
            next_en = 1'b1;
            case (output_function_select)
               cmtim_pkg::IOF_01: next_pin = output_initial_level;
               cmtim_pkg::IOF_10: next_pin = pwm_active ?
                  output_initial_level : ~output_initial_level;
               default: next_pin = ~output_initial_level;
            endcase
            next_pin = next_pin ^ output_polarity;
         end
         default: begin
            next_pin = 1'b0;
            next_en = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_output_pin <= 1'b0;
         timer_output_en <= 1'b0;
      end else begin
         timer_output_pin <= next_pin;
         timer_output_en <= next_en;
      end
   end

   // Control register writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl0 <= cmtim_pkg::CTL0_RST;
         ctl1 <= cmtim_pkg::CTL1_RST;
      end else if (done && pwrite) begin
         if (ofs == cmtim_pkg::OFS_CTL0) begin
            ctl0 <= pwdata[7:0];
         end
         if (ofs == cmtim_pkg::OFS_CTL1) begin
            ctl1 <= pwdata[7:0];
         end
      end
   end

   // Low-byte buffer moves on a compare A low byte write and on high byte reads
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lo_buf <= 8'h00;
         compare_a_value <= cmtim_pkg::CMPA_RST;
      end else if (done && pwrite) begin
         if (ofs == cmtim_pkg::OFS_CMPA_LO) begin
            lo_buf <= pwdata[7:0];
         end else if (ofs == cmtim_pkg::OFS_CMPA_HI) begin
            compare_a_value <= {pwdata[1:0], lo_buf};
         end
      end else if (access && !pwrite) begin
         // Same edge that captures the high byte, so a running count
         // cannot carry between the two halves
         if (ofs == cmtim_pkg::OFS_CNT_HI) begin
            lo_buf <= count[7:0];
         end else if (ofs == cmtim_pkg::OFS_CMPA_HI) begin
            lo_buf <= compare_a_value[7:0];
         end
      end
   end

   // Read mux; low bytes read the buffer, not the live value
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      case (ofs)
         cmtim_pkg::OFS_CTL0: next_rdata[7:0] = ctl0;
         cmtim_pkg::OFS_CTL1: next_rdata[7:0] = ctl1;
         cmtim_pkg::OFS_CNT_LO: next_rdata[7:0] = lo_buf;
         cmtim_pkg::OFS_CNT_HI: next_rdata[1:0] = count[9:8];
         cmtim_pkg::OFS_CMPA_LO: next_rdata[7:0] = lo_buf;
         cmtim_pkg::OFS_CMPA_HI: next_rdata[1:0] = compare_a_value[9:8];
         default: next_err = 1'b1;
      endcase
   end

   // One wait state keeps every bus output registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= access;
         pslverr <= access & next_err;
         prdata <= (access && !pwrite) ? next_rdata : 32'h0000_0000;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_on_clear;
      on_rise |=> count == 10'h000;
   endproperty
   a_on_clear: assert property (p_on_clear)
      else $error("count not cleared on counter-on rise");

   property p_off_hold;
      !counter_on |=> $stable(count);
   endproperty
   a_off_hold: assert property (p_off_hold)
      else $error("count moved while timer off");

   property p_pause_hold;
      counter_on && on_prev && counter_pause |=> $stable(count);
   endproperty
   a_pause_hold: assert property (p_pause_hold)
      else $error("count moved while paused");

   property p_count_up;
      tk.tick && run && !clr_now |=> count == $past(count) + 10'h001;
   endproperty
   a_count_up: assert property (p_count_up)
      else $error("count did not advance by one");

   property p_clear_a;
      tk.tick && run && a_hit && mode != cmtim_pkg::MODE_PWM &&
         clear_condition_select |=> count == 10'h000 ##0 compare_a_flag;
   endproperty
   a_clear_a: assert property (p_clear_a)
      else $error("A match did not clear the counter");

   property p_no_p_flag;
      mode == cmtim_pkg::MODE_CMP && clear_condition_select
         && $stable(ctl1) |=> !compare_p_flag;
   endproperty
   a_no_p_flag: assert property (p_no_p_flag)
      else $error("P flag raised while A owns the clear");

   property p_event;
      tk.tick && run && clr_now |=> timer_event;
   endproperty
   a_event: assert property (p_event)
      else $error("missing timer event on counter clear");

   property p_init_level;
      on_rise && mode == cmtim_pkg::MODE_CMP && $stable(ctl1) ##1
         !a_evt && $stable(ctl1) |=> timer_output_pin ==
         (output_initial_level ^ output_polarity);
   endproperty
   a_init_level: assert property (p_init_level)
      else $error("pin not at initial level after start");

   property p_timer_pin;
      mode == cmtim_pkg::MODE_TMR |=> !timer_output_en && !timer_output_pin;
   endproperty
   a_timer_pin: assert property (p_timer_pin)
      else $error("pin driven in timer mode");

   property p_pwm_forced;
      mode == cmtim_pkg::MODE_PWM && output_function_select ==
         cmtim_pkg::IOF_00 |=> timer_output_pin !=
         ($past(output_initial_level) ^ $past(output_polarity));
   endproperty
   a_pwm_forced: assert property (p_pwm_forced)
      else $error("forced inactive PWM level wrong");

   property p_compare_a_value_write;
      done && pwrite && ofs == cmtim_pkg::OFS_CMPA_HI |=>
         compare_a_value == {$past(pwdata[1:0]), $past(lo_buf)};
   endproperty
   a_compare_a_value_write: assert property (p_compare_a_value_write)
      else $error("compare A not loaded from buffer");

   c_a_match: cover property (a_evt ##1 compare_a_flag);
   c_wrap: cover property (tk.tick && run && ovf);
   c_pwm_run: cover property (mode == cmtim_pkg::MODE_PWM && pwm_active
      ##1 !pwm_active);
   c_bus_err: cover property (pready && pslverr);
endmodule // cmtim_top

// ===== cmtim_top_tb.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
error_cnt++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module cmtim_top_tb;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic pready;
   logic pslverr;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic high_clk = 1'b0;
   logic sub_clk = 1'b0;
   logic ext_in = 1'b0;
   logic pin;
   logic pin_en;
   logic fa;
   logic fp;
   logic tev;
   logic [31:0] rnd;
   logic [31:0] rd;
   logic er;
   int error_cnt = 0;
   int check_count = 0;
   int cyc = 0;

   cmtim_top u_cmtim_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .high_clk(high_clk), .sub_clk(sub_clk), .external_count_input(ext_in),
      .timer_output_pin(pin), .timer_output_en(pin_en), .compare_a_flag(fa),
      .compare_p_flag(fp), .timer_event(tev));

   // System clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Slow sources: high period 4, sub period 6, pin period 8 cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc % 2 == 1) high_clk <= ~high_clk;
      if (cyc % 3 == 2) sub_clk <= ~sub_clk;
      if (cyc % 4 == 3) ext_in <= ~ext_in;
   end

   // Hang guard, well above the expected run length
   initial begin
      repeat (80000) @(posedge pclk);
      error_cnt++;
      final_report();
   end

   function logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Counter clocks per tick for each source code
   function int div(input int k);
      case (k)
         0: return 4;
         1: return 1;
         2: return 64;
         3: return 256;
         4, 5: return 6;
         default: return 8;
      endcase
   endfunction

   // High cycles of the pin over one PWM window
   function int pwm_exp(input logic [7:0] c, input int d, input int w);
      int a;
      a = c[1] ? 128 : d;
      if (c[5:4] == 2'h0) a = 0;
      if (c[5:4] == 2'h1) a = w;
      return (c[3] ^ c[2]) ? a : w - a;
   endfunction

   // One APB transfer; holds everything until pready is seen
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Ends when pready is seen; if it never comes, only the hang guard ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // High byte first so the low byte comes from the buffer
   task rd_cnt(output logic [9:0] c);
      apb(1'b0, 12'h00c, 32'h0);
      c[9:8] = rd[1:0];
      apb(1'b0, 12'h008, 32'h0);
      c[7:0] = rd[7:0];
   endtask

   // Timer off before mode or output changes, then on again
   task setup(input logic [7:0] c1, input logic [9:0] a, input logic [7:0] c0);
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h004, {24'h0, c1});
      apb(1'b1, 12'h010, {24'h0, a[7:0]});
      apb(1'b1, 12'h014, {30'h0, a[9:8]});
      apb(1'b1, 12'h000, {24'h0, c0});
   endtask

   task wait_ev();
      do begin
         @(posedge pclk);
      end while (tev !== 1'b1);
   endtask

   // Cycles between two events; a lost event is left to the hang guard
   task gap(output int g);
      wait_ev();
      g = 0;
      do begin
         @(posedge pclk);
         g++;
      end while (tev !== 1'b1);
   endtask

   task final_report();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      int g;
      int h;
      int d;
      logic [7:0] c1;
      logic [7:0] pw [7];
      logic p1;
      logic [9:0] c;
      logic [9:0] c2;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h0;
      pwdata = 32'h0;
      presetn = 1'b0;
      rnd = 32'd98392;
      pw = '{8'ha8, 8'hac, 8'ha0, 8'ha9, 8'h88, 8'h98, 8'haa};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, unmapped place, read-only counter
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctl0", 32'h0, rd)
      apb(1'b0, 12'h004, 32'h0);
      `CHK("ctl1", 32'h0, rd)
      apb(1'b0, 12'h020, 32'h0);
      `CHK("unmapped", 1'b1, er)
      apb(1'b1, 12'h00c, 32'h3);
      `CHK("cnt_wr", 1'b0, er)
      rnd = lfsr(rnd);
      apb(1'b1, 12'h010, {24'h0, rnd[7:0]});
      apb(1'b1, 12'h014, {30'h0, rnd[9:8]});
      apb(1'b0, 12'h014, 32'h0);
      `CHK("cmpa_hi", {30'h0, rnd[9:8]}, rd)
      apb(1'b0, 12'h010, 32'h0);
      `CHK("cmpa_lo", {24'h0, rnd[7:0]}, rd)
      apb(1'b0, 12'h00c, 32'h0);
      `CHK("cnt_ro", 32'h0, rd)
      apb(1'b0, 12'h010, 32'h0);
      `CHK("shared_buf", 32'h0, rd)
      $display("test registers done");
      // Every clock source, clear on A match at 4
      for (int i = 0; i < 8; i++) begin
         setup(8'hc1, 10'd4, {1'b0, i[2:0], 4'h8});
         gap(g);
         `CHK("src_gap", div(i) * 4, g)
         `CHK("src_fa", 1'b1, fa)
         `CHK("src_fp", 1'b0, fp)
         `CHK("tmr_en", 1'b0, pin_en)
      end
      $display("test sources done");
      // Period clearing; A of zero never moves the pin
      setup(8'h18, 10'd0, 8'h19);
      gap(g);
      `CHK("p_gap", 128, g)
      `CHK("p_fp", 1'b1, fp)
      `CHK("p_fa", 1'b0, fa)
      `CHK("pin_p", 1'b1, pin)
      setup(8'h18, 10'd0, 8'h18);
      gap(g);
      `CHK("ovf_gap", 1024, g)
      `CHK("ovf_fp", 1'b1, fp)
      $display("test period done");
      // Compare output actions with level and polarity
      for (int i = 0; i < 12; i++) begin
         c1 = {2'b00, 2'(i / 4), i[0], i[1], 2'b01};
         setup(c1, 10'd8, 8'h18);
         repeat (64) @(posedge pclk);
         p1 = (i / 4 == 0) ? i[0] : (i / 4 == 2);
         `CHK("cmp_pin", p1 ^ i[1], pin)
         `CHK("cmp_en", 1'b1, pin_en)
      end
      setup(8'h31, 10'd8, 8'h18);
      wait_ev();
      repeat (3) @(posedge pclk);
      p1 = pin;
      wait_ev();
      repeat (3) @(posedge pclk);
      `CHK("toggle", ~p1, pin)
      $display("test compare done");
      // PWM duty, level, polarity, forcing, swap
      rnd = lfsr(rnd);
      d = int'(rnd[6:0] | 7'h01);
      for (int i = 0; i < 7; i++) begin
         setup(pw[i], pw[i][1] ? 10'd256 : 10'(d), 8'h19);
         repeat (300) @(posedge pclk);
         hi_cnt(pw[i][1] ? 256 : 128, h);
         `CHK("pwm_hi", pwm_exp(pw[i], d, pw[i][1] ? 256 : 128), h)
         `CHK("pwm_en", 1'b1, pin_en)
      end
      $display("test pwm done");
      // Pause, stop and restart of the count
      setup(8'hc0, 10'd0, 8'h18);
      repeat (20) @(posedge pclk);
      apb(1'b1, 12'h000, 32'h98);
      rd_cnt(c);
      repeat (20) @(posedge pclk);
      rd_cnt(c2);
      `CHK("paused", c, c2)
      apb(1'b1, 12'h000, 32'h18);
      rd_cnt(c2);
      `CHK("resumed", 1'b1, c2 > c)
      apb(1'b1, 12'h000, 32'h10);
      rd_cnt(c);
      repeat (20) @(posedge pclk);
      rd_cnt(c2);
      `CHK("stopped", c, c2)
      apb(1'b1, 12'h000, 32'h18);
      rd_cnt(c);
      `CHK("restart", 1'b1, c < 10'd16)
      // Undefined mode keeps the pin released
      setup(8'h40, 10'd0, 8'h18);
      repeat (4) @(posedge pclk);
      `CHK("undef_en", 1'b0, pin_en)
      $display("test control done");
      final_report();
   end

   task hi_cnt(input int n, output int h);
      h = 0;
      repeat (n) begin
         @(posedge pclk);
         if (pin === 1'b1) h++;
      end
   endtask
endmodule // cmtim_top_tb
